// *** design/utp_cell_port.v ***
// utopia level 2 atm-layer cell port: transmit and receive cell engines
// assumes link clocks far slower than clk; link-side outputs change only at sampled link edges or when drive changes
`timescale 1ns/10ps
`include "utp_consts.vh"
module utp_cell_port (
    input wire clk,
    input wire sys_rst,
    input wire power_on_reset_in_n,
    input wire port_configured,
    input wire multi_phy,
    input wire [4:0] phy_count,
    // transmit link
    input wire tx_cell_clk,
    output reg tx_enable_out_n,
    output wire tx_enable_out_oe,
    output reg tx_cell_start,
    output wire tx_cell_start_oe,
    output reg [7:0] tx_cell_byte,
    output wire tx_cell_byte_oe,
    output reg [4:0] tx_phy_select_addr,
    input wire tx_cell_space_in,
    // transmit user side
    input wire [7:0] tx_user_byte,
    input wire tx_user_valid,
    output wire tx_user_ready,
    output reg [4:0] tx_user_phy,
    // receive link
    input wire rx_cell_clk,
    input wire rx_cell_avail_in,
    input wire rx_cell_start,
    input wire [7:0] rx_cell_byte,
    output reg [4:0] rx_phy_select_addr,
    output reg rx_enable_out_n,
    output wire rx_enable_out_oe,
    // receive user side
    output reg [7:0] rx_user_byte,
    output reg rx_user_valid,
    output reg rx_user_first,
    output reg [4:0] rx_user_phy
);
    localparam ST_POLL = 4'b0001;
    localparam ST_SEL = 4'b0010;
    localparam ST_XFER = 4'b0100;
    localparam ST_WAIT = 4'b1000;

    function [4:0] next_addr;
        input [4:0] cur;
        input [4:0] cnt;
        begin
            if (cur >= cnt) begin
                next_addr = 5'h00;
            end else begin
                next_addr = cur + 5'h01;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // synchronisers, edges and output enables
    wire [1:0] clk_s;
    wire tx_edge;
    wire rx_edge;
    wire [10:0] rx_s;
    wire tx_space_s;
    wire por_s;
    reg drive;
    utp_sync #(.W(2)) u_clk_sync (
        .clk(clk), .sys_rst(sys_rst),
        .d({rx_cell_clk, tx_cell_clk}), .q(clk_s)
    );
    // data pins sampled beside the clocks; they are stable for a whole link period
    utp_sync #(.W(12)) u_pin_sync (
        .clk(clk), .sys_rst(sys_rst),
        .d({tx_cell_space_in, rx_cell_avail_in, rx_cell_start, rx_cell_byte, power_on_reset_in_n}),
        .q({tx_space_s, rx_s[10:0]})
    );
    assign por_s = rx_s[0];
    utp_edge u_tx_edge (.clk(clk), .sys_rst(sys_rst), .lvl(clk_s[0]), .rise(tx_edge));
    utp_edge u_rx_edge (.clk(clk), .sys_rst(sys_rst), .lvl(clk_s[1]), .rise(rx_edge));

    always @(posedge clk) begin
        if (sys_rst) begin
            drive <= 1'b0;
        end else begin
            drive <= port_configured & por_s;
        end
    end
    assign tx_enable_out_oe = drive;
    assign tx_cell_start_oe = drive;
    assign tx_cell_byte_oe = drive;
    assign rx_enable_out_oe = drive;

    ////////////////////////////////////////////////////////////////////////
    // transmit engine
    reg [3:0] tx_st;
    reg [5:0] tx_cnt;
    reg [4:0] tx_poll;
    reg tx_poll_live;
    // a byte is taken from the user only at a link edge inside a cell
    assign tx_user_ready = drive & tx_edge & (tx_st == ST_XFER);

    always @(posedge clk) begin
        if (sys_rst) begin
            tx_st <= ST_POLL;
            tx_cnt <= 6'h00;
            tx_poll <= 5'h00;
            tx_poll_live <= 1'b0;
            tx_enable_out_n <= 1'b1;
            tx_cell_start <= 1'b0;
            tx_cell_byte <= 8'h00;
            tx_phy_select_addr <= `UTP_ADDR_NULL;
            tx_user_phy <= 5'h00;
        end else if (!drive) begin
            tx_st <= ST_POLL;
            tx_enable_out_n <= 1'b1;
            tx_cell_start <= 1'b0;
            tx_poll_live <= 1'b0;
        end else if (tx_edge) begin
            case (tx_st)
                ST_POLL: begin
                    tx_cell_start <= 1'b0;
                    if (!multi_phy) begin
                        // single phy: wait for space and a user byte
                        if (tx_space_s && tx_user_valid) begin
                            tx_st <= ST_XFER;
                        end
                    end else begin
                        // poll answer for the address shown one link clock earlier
                        if (tx_poll_live && tx_space_s && tx_user_valid) begin
                            tx_phy_select_addr <= tx_phy_select_addr;
                            tx_user_phy <= tx_poll;
                            tx_st <= ST_SEL;
                        end else begin
                            tx_poll <= next_addr(tx_poll, phy_count);
                            tx_phy_select_addr <= next_addr(tx_poll, phy_count);
                            tx_poll_live <= 1'b1;
                        end
                    end
                end
                ST_SEL: begin
                    // address held with enable high for this clock
                    tx_enable_out_n <= 1'b1;
                    tx_st <= ST_XFER;
                end
                ST_XFER: begin
                    tx_enable_out_n <= 1'b0;
                    tx_cell_byte <= tx_user_byte;
                    tx_cell_start <= (tx_cnt == 6'h00);
                    if (tx_cnt == `UTP_CELL_LAST) begin
                        tx_cnt <= 6'h00;
                        tx_st <= ST_WAIT;
                    end else begin
                        tx_cnt <= tx_cnt + 6'h01;
                    end
                end
                ST_WAIT: begin
                    tx_enable_out_n <= 1'b1;
                    tx_cell_start <= 1'b0;
                    tx_poll_live <= 1'b0;
                    tx_st <= ST_POLL;
                end
                default: begin
                    tx_st <= ST_POLL;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive engine
    reg [3:0] rx_st;
    reg [5:0] rx_cnt;
    reg [4:0] rx_poll;
    reg rx_poll_live;
    wire rx_avail_s = rx_s[10];
    wire rx_start_s = rx_s[9];
    wire [7:0] rx_byte_s = rx_s[8:1];

    always @(posedge clk) begin
        if (sys_rst) begin
            rx_st <= ST_POLL;
            rx_cnt <= 6'h00;
            rx_poll <= 5'h00;
            rx_poll_live <= 1'b0;
            rx_enable_out_n <= 1'b1;
            rx_phy_select_addr <= `UTP_ADDR_NULL;
            rx_user_byte <= 8'h00;
            rx_user_valid <= 1'b0;
            rx_user_first <= 1'b0;
            rx_user_phy <= 5'h00;
        end else begin
            rx_user_valid <= 1'b0;
            if (!drive) begin
                rx_st <= ST_POLL;
                rx_enable_out_n <= 1'b1;
                rx_poll_live <= 1'b0;
            end else if (rx_edge) begin
                // enable was low through the past link clock, so the phy drove this edge
                if (!rx_enable_out_n && (rx_cnt != 6'h00 || rx_start_s)) begin
                    rx_user_byte <= rx_byte_s;
                    rx_user_valid <= 1'b1;
                    rx_user_first <= rx_start_s;
                    rx_cnt <= (rx_cnt == `UTP_CELL_LAST) ? 6'h00 : rx_cnt + 6'h01;
                end
                case (rx_st)
                    ST_POLL: begin
                        if (!multi_phy) begin
                            if (rx_avail_s) begin
                                rx_enable_out_n <= 1'b0;
                                rx_st <= ST_XFER;
                            end
                        end else if (rx_poll_live && rx_avail_s) begin
                            rx_user_phy <= rx_poll;
                            rx_st <= ST_SEL;
                        end else begin
                            rx_poll <= next_addr(rx_poll, phy_count);
                            rx_phy_select_addr <= next_addr(rx_poll, phy_count);
                            rx_poll_live <= 1'b1;
                        end
                    end
                    ST_SEL: begin
                        rx_enable_out_n <= 1'b0;
                        rx_st <= ST_XFER;
                    end
                    ST_XFER: begin
                        if (!rx_enable_out_n && rx_cnt == `UTP_CELL_LAST) begin
                            rx_enable_out_n <= 1'b1;
                            rx_st <= ST_WAIT;
                        end
                    end
                    ST_WAIT: begin
                        rx_poll_live <= 1'b0;
                        rx_st <= ST_POLL;
                    end
                    default: begin
                        rx_st <= ST_POLL;
                    end
                endcase
            end
        end
    end
endmodule // utp_cell_port

// *** design/utp_consts.vh ***
// utopia level 2 atm-layer cell port: shared constants
// assumes inclusion by bare name from the design modules
`ifndef UTP_CONSTS_VH
`define UTP_CONSTS_VH
`define UTP_CELL_LEN 6'd53
`define UTP_CELL_LAST 6'd52
`define UTP_CNT_W 6
`define UTP_ADDR_W 5
`define UTP_BYTE_W 8
`define UTP_ADDR_NULL 5'h1f
`endif

// *** design/utp_edge.v ***
// rising-edge finder on an already synchronised link clock
// assumes clk runs at least four times faster than the link clock
`timescale 1ns/10ps
module utp_edge (
    input wire clk,
    input wire sys_rst,
    input wire lvl,
    output wire rise
);
    reg last;
    always @(posedge clk) begin
        if (sys_rst) begin
            last <= 1'b0;
        end else begin
            last <= lvl;
        end
    end
    assign rise = lvl & ~last;
endmodule // utp_edge

// *** design/utp_sync.v ***
// two-flop synchroniser for a bus of levels coming from outside clk
// assumes the input holds stable between link-clock edges
`timescale 1ns/10ps
module utp_sync #(
    parameter W = 1
) (
    input wire clk,
    input wire sys_rst,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta;
    always @(posedge clk) begin
        if (sys_rst) begin
            meta <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // utp_sync

// *** verification/testbench.sv ***
// bench: two cells each way, multi-phy then single-phy
// assumes utp_cell_port, utp_phy_model and the bound checker
`timescale 1ns/10ps
module testbench;
reg clk = 1'b0;
reg sys_rst = 1'b1;
reg power_on_reset_in_n = 1'b0;
reg port_configured = 1'b0;
reg multi_phy = 1'b0;
reg [4:0] phy_count = 5'h03;
reg space_ok = 1'b0;
reg [7:0] rx_ncell = 8'h00;
reg [7:0] tx_user_byte = 8'h00;
reg tx_user_valid = 1'b0;
integer seed = 53156;
integer n_fail = 0;
integer compares = 0;
reg [8:0] sq[$];
reg [8:0] txq[$];
reg [8:0] rxq[$];
wire tx_cell_clk, rx_cell_clk, tx_enable_out_n, tx_enable_out_oe, tx_cell_start;
wire tx_cell_start_oe, tx_cell_byte_oe, tx_cell_space_in, tx_user_ready, rx_cell_avail_in;
wire rx_cell_start, rx_enable_out_n, rx_enable_out_oe, rx_user_valid, rx_user_first, got_v;
wire [7:0] tx_cell_byte, rx_cell_byte, rx_user_byte;
wire [4:0] tx_phy_select_addr, tx_user_phy, rx_phy_select_addr, rx_user_phy;
wire [8:0] got_w;
utp_cell_port utp_cell_port_inst (.*);
utp_phy_model utp_phy_model_inst (.*);
////////////////////////////////////////////////////////////
always #25 clk = ~clk;
task check(input [8:0] seen, input [8:0] exp, input [63:0] what);
    begin
        compares = compares + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("unexpected %0s: expected %h, seen %h", what, exp, seen);
        end
    end
endtask
task give_verdict;
    begin
        if (n_fail == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
endtask
always @(posedge clk) begin
    if (tx_user_valid && tx_user_ready)
        void'(sq.pop_front());
    #1;
    tx_user_valid = sq.size() > 0;
    tx_user_byte = (sq.size() > 0) ? sq[0][7:0] : 8'h00;
end
always @(posedge tx_cell_clk)
    if (got_v) check(got_w, txq.pop_front(), "tx byte");
always @(posedge clk)
    if (rx_user_valid === 1'b1) check({rx_user_first, rx_user_byte}, rxq.pop_front(), "rx byte");
task phase(input m);
    integer c, i, b;
    begin
        #1;
        sys_rst = 1'b1;
        power_on_reset_in_n = 1'b0;
        port_configured = 1'b0;
        multi_phy = m;
        space_ok = 1'b0;
        repeat (8) @(posedge clk);
        #1 sys_rst = 1'b0;
        repeat (4) @(posedge clk);
        check({7'h00, tx_cell_byte_oe, rx_enable_out_oe}, 9'h000, "oe");
        #1 power_on_reset_in_n = 1'b1;
        port_configured = 1'b1;
        for (c = 0; c < 2; c = c + 1) begin
            b = $random(seed);
            for (i = 0; i < 53; i = i + 1) begin
                sq.push_back({i == 0, b[7:0] + i[7:0]});
                txq.push_back({i == 0, b[7:0] + i[7:0]});
                rxq.push_back({i == 0, rx_ncell * 8'h07 + i[7:0]});
            end
            rx_ncell = rx_ncell + 8'h01;
        end
        // phy refuses space: no tx byte may leave
        repeat (60) @(posedge clk);
        check(9'(txq.size()), 9'h06a, "tx stall");
        #1 space_ok = 1'b1;
        i = 0;
        while ((txq.size() + rxq.size()) > 0 && i < 20000) begin
            @(posedge clk);
            i = i + 1;
        end
        check(9'(txq.size() + rxq.size()), 9'h000, "cells");
        if (m) check({4'h0, tx_user_phy}, 9'h002, "tx phy");
        if (m) check({4'h0, rx_user_phy}, 9'h002, "rx phy");
    end
endtask
initial begin
    #1000000;
    n_fail = n_fail + 1;
    give_verdict;
end
initial begin
    phase(1'b1);
    phase(1'b0);
    give_verdict;
end
endmodule // testbench

// *** verification/utp_checker.sv ***
// checker: pin timing of the cell port
// assumes it is bound onto utp_cell_port
`timescale 1ns/10ps
module utp_checker (
    input wire clk,
    input wire sys_rst,
    input wire power_on_reset_in_n,
    input wire tx_enable_out_n,
    input wire tx_enable_out_oe,
    input wire tx_cell_start,
    input wire [7:0] tx_cell_byte,
    input wire tx_cell_byte_oe,
    input wire rx_enable_out_n,
    input wire rx_enable_out_oe,
    input wire rx_user_valid,
    input wire rx_user_first
);
default clocking cb @(posedge clk); endclocking
default disable iff (sys_rst);
////////////////////////////////////////////////////////////
AST_TX_POR: assert property (!power_on_reset_in_n [*4] |-> !tx_cell_byte_oe)
    else $error("tx pins driven in reset");
AST_RX_POR: assert property (!power_on_reset_in_n [*4] |-> !rx_enable_out_oe)
    else $error("rx enable driven in reset");
AST_SOC_ENB: assert property (tx_cell_start && tx_cell_byte_oe |-> !tx_enable_out_n)
    else $error("start without enable");
AST_SEL_SOC: assert property ($fell(tx_enable_out_n) && tx_enable_out_oe |-> tx_cell_start)
    else $error("first byte not flagged");
AST_TX_HOLD: assert property ($changed(tx_cell_byte) |=> $stable(tx_cell_byte) [*3])
    else $error("tx byte moved between link edges");
AST_RX_HOLD: assert property ($changed(rx_enable_out_n) |=> $stable(rx_enable_out_n) [*3])
    else $error("rx enable moved between link edges");
AST_RX_PULSE: assert property (rx_user_valid |=> !rx_user_valid [*4])
    else $error("rx valid not one per link edge");
AST_RX_FIRST: assert property ($rose(rx_user_first) |-> rx_user_valid)
    else $error("first flag without byte");
endmodule // utp_checker
bind utp_cell_port utp_checker utp_checker_inst (.*);

// *** verification/utp_phy_model.sv ***
// model: one phy at address me, free running link clocks
// assumes idle lines fall to their pull-down level
`timescale 1ns/10ps
module utp_phy_model #(
    parameter [4:0] me = 5'h02
) (
    output reg tx_cell_clk = 1'b0,
    output reg rx_cell_clk = 1'b0,
    input wire multi_phy,
    input wire space_ok,
    input wire [7:0] rx_ncell,
    input wire tx_enable_out_n,
    input wire tx_enable_out_oe,
    input wire tx_cell_start,
    input wire [7:0] tx_cell_byte,
    input wire [4:0] tx_phy_select_addr,
    output reg tx_cell_space_in = 1'b0,
    input wire [4:0] rx_phy_select_addr,
    input wire rx_enable_out_n,
    output reg rx_cell_avail_in = 1'b0,
    output reg rx_cell_start = 1'b0,
    output reg [7:0] rx_cell_byte = 8'h00,
    output reg got_v = 1'b0,
    output reg [8:0] got_w = 9'h000
);
reg tsel = 1'b0;
reg rsel = 1'b0;
reg [7:0] sent = 8'h00;
reg [5:0] cnt = 6'h00;
////////////////////////////////////////////////////////////
always #200 tx_cell_clk = ~tx_cell_clk;
initial #90 forever #200 rx_cell_clk = ~rx_cell_clk;
always @(posedge tx_cell_clk) begin
    if (tx_enable_out_n)
        tsel <= !multi_phy || tx_phy_select_addr == me;
    tx_cell_space_in <= space_ok && (!multi_phy || tx_phy_select_addr == me);
    got_v <= !tx_enable_out_n && tx_enable_out_oe && tsel;
    got_w <= {tx_cell_start, tx_cell_byte};
end
always @(posedge rx_cell_clk) begin
    if (rx_enable_out_n)
        rsel <= !multi_phy || rx_phy_select_addr == me;
    rx_cell_avail_in <= sent < rx_ncell && (!multi_phy || rx_phy_select_addr == me);
    // only the selected phy drives, and only while enable is low
    if (!rx_enable_out_n && rsel && sent < rx_ncell) begin
        rx_cell_byte <= sent * 8'h07 + cnt;
        rx_cell_start <= cnt == 6'h00;
        cnt <= (cnt == 6'h34) ? 6'h00 : cnt + 6'h01;
        sent <= sent + {7'h00, cnt == 6'h34};
    end else begin
        rx_cell_byte <= 8'h00;
        rx_cell_start <= 1'b0;
    end
end
endmodule // utp_phy_model
